//--- pkg/dul_pkg.sv
// package: register map, field layout and types for the converter update latch block
package dul_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          CHAN_N        = 2;
  localparam int          WORD_W        = 12;
  localparam int          BYTE_W        = 8;

  // register map: channel n at n * CHAN_STRIDE
  localparam logic [7:0]  CHAN_STRIDE   = 8'h10;
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_DATA_LOW  = 4'h4;
  localparam logic [3:0]  OFF_DATA_HIGH = 4'h8;
  localparam logic [3:0]  OFF_LATCHED   = 4'hC;
  localparam logic [2:0]  MAP_TOP_BITS  = 3'h0;

  // control register fields
  localparam int          CTRL_FMT_LSB  = 0;
  localparam int          CTRL_FMT_W    = 3;
  localparam int          CTRL_MODE_LSB = 3;
  localparam int          CTRL_MODE_W   = 2;
  localparam int          CTRL_W        = CTRL_MODE_W + CTRL_FMT_W;

  // update trigger select codes
  localparam logic [1:0]  MODE_IMMEDIATE = 2'h0;
  localparam logic [1:0]  MODE_TIMER3    = 2'h1;
  localparam logic [1:0]  MODE_TIMER4    = 2'h2;
  localparam logic [1:0]  MODE_TIMER2    = 2'h3;

  // data format select codes; 3'h5..3'h7 fall back to left justified
  localparam logic [2:0]  FMT_SHIFT0    = 3'h0;
  localparam logic [2:0]  FMT_SHIFT1    = 3'h1;
  localparam logic [2:0]  FMT_SHIFT2    = 3'h2;
  localparam logic [2:0]  FMT_SHIFT3    = 3'h3;
  localparam logic [2:0]  FMT_LEFT      = 3'h4;

  // reset values
  localparam logic [4:0]  CTRL_RESET    = 5'h00;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [11:0] WORD_RESET    = 12'h000;

  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic [CTRL_MODE_W-1:0] mode;
    logic [CTRL_FMT_W-1:0]  fmt;
  } dul_ctrl_t;

  typedef struct packed {
    logic [BYTE_W-1:0] high;
    logic [BYTE_W-1:0] low;
  } dul_data_t;

endpackage : dul_pkg

//--- hw/dul_channel.sv
// converter channel: data justification and input latch transfer
`timescale 1ns/1ps
module dul_channel (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  input  wire dul_pkg::dul_ctrl_t i_ctrl,
  input  wire dul_pkg::dul_data_t i_data,
  input  wire logic               i_high_wr,
  input  wire logic               i_tmr2_ovf,
  input  wire logic               i_tmr3_ovf,
  input  wire logic               i_tmr4_ovf,
  output logic [11:0]             o_word
);

  logic        imm_pend_reg;
  logic [11:0] word_reg;
  wire  [11:0] w_shift0;
  wire  [11:0] w_shift1;
  wire  [11:0] w_shift2;
  wire  [11:0] w_shift3;
  wire  [11:0] w_left;
  wire  [11:0] fmt_word;
  wire         is_imm;
  wire         tmr_hit;
  wire         latch_now;

  ////////////////////////////////////////////////////////////////////////////////
  // justification of the 12-bit word inside the high:low pair
  assign w_shift0 = {i_data.high[3:0], i_data.low};
  assign w_shift1 = {i_data.high[4:0], i_data.low[7:1]};
  assign w_shift2 = {i_data.high[5:0], i_data.low[7:2]};
  assign w_shift3 = {i_data.high[6:0], i_data.low[7:3]};
  assign w_left   = {i_data.high, i_data.low[7:4]};
  // reserved codes behave as left justified so no code leaves the output undefined
  assign fmt_word = (i_ctrl.fmt == dul_pkg::FMT_SHIFT0) ? w_shift0 :
                    (i_ctrl.fmt == dul_pkg::FMT_SHIFT1) ? w_shift1 :
                    (i_ctrl.fmt == dul_pkg::FMT_SHIFT2) ? w_shift2 :
                    (i_ctrl.fmt == dul_pkg::FMT_SHIFT3) ? w_shift3 : w_left;

  ////////////////////////////////////////////////////////////////////////////////
  // trigger selection
  assign is_imm    = (i_ctrl.mode == dul_pkg::MODE_IMMEDIATE);
  assign tmr_hit   = ((i_ctrl.mode == dul_pkg::MODE_TIMER3) & i_tmr3_ovf) |
                     ((i_ctrl.mode == dul_pkg::MODE_TIMER4) & i_tmr4_ovf) |
                     ((i_ctrl.mode == dul_pkg::MODE_TIMER2) & i_tmr2_ovf);
  assign latch_now = imm_pend_reg | tmr_hit;

  // pending flag lets the high byte settle in its register before the copy
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      imm_pend_reg <= 1'b0;
    end else begin
      imm_pend_reg <= i_high_wr & is_imm;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_reg <= dul_pkg::WORD_RESET;
    end else if (latch_now) begin
      word_reg <= fmt_word;
    end
  end

  assign o_word = word_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_imm_write;
    i_high_wr && is_imm;
  endsequence

  property p_imm_latch;
    s_imm_write |=> ##1 (o_word == $past(fmt_word));
  endproperty
  a_imm_latch: assert property (p_imm_latch) else $error("high write did not update");

  property p_hold;
    !latch_now |=> $stable(o_word);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without a trigger");

  property p_timer_mode_no_imm;
    (i_high_wr && !is_imm) |=> !imm_pend_reg;
  endproperty
  a_timer_mode_no_imm: assert property (p_timer_mode_no_imm)
    else $error("write in timer mode armed an immediate copy");

  property p_timer_copy;
    tmr_hit |=> (o_word == $past(fmt_word));
  endproperty
  a_timer_copy: assert property (p_timer_copy) else $error("timer overflow copy wrong");

  property p_wrong_timer;
    (i_ctrl.mode == dul_pkg::MODE_TIMER3 && i_tmr2_ovf && !i_tmr3_ovf && !imm_pend_reg)
      |=> $stable(o_word);
  endproperty
  a_wrong_timer: assert property (p_wrong_timer) else $error("unselected timer copied");

  property p_fmt_right;
    (latch_now && i_ctrl.fmt == dul_pkg::FMT_SHIFT0)
      |=> (o_word == {$past(i_data.high[3:0]), $past(i_data.low)});
  endproperty
  a_fmt_right: assert property (p_fmt_right) else $error("right justified placement wrong");

  property p_fmt_reserved;
    (latch_now && i_ctrl.fmt[2])
      |=> (o_word == {$past(i_data.high), $past(i_data.low[7:4])});
  endproperty
  a_fmt_reserved: assert property (p_fmt_reserved)
    else $error("left or reserved placement wrong");

endmodule : dul_channel

//--- hw/dul_dac_latch.sv
// top: AXI4-Lite register file and two converter update latch channels
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dul_dac_latch (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  i_awaddr,
  input  wire logic [2:0]  i_awprot,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // read address
  input  wire logic [7:0]  i_araddr,
  input  wire logic [2:0]  i_arprot,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // timer overflow pulses
  input  wire logic        i_tmr2_ovf,
  input  wire logic        i_tmr3_ovf,
  input  wire logic        i_tmr4_ovf,
  // converter input latches
  output logic [11:0]      o_first_word,
  output logic [11:0]      o_second_word
);

  localparam int NCH = dul_pkg::CHAN_N;

  logic               aw_held_reg;
  logic [7:0]         awaddr_reg;
  logic               w_held_reg;
  logic [31:0]        wdata_reg;
  logic [3:0]         wstrb_reg;
  logic               bvalid_reg;
  logic [1:0]         bresp_reg;
  logic               rvalid_reg;
  logic [1:0]         rresp_reg;
  logic [31:0]        rdata_reg;
  dul_pkg::dul_ctrl_t ctrl_reg [NCH];
  dul_pkg::dul_data_t data_reg [NCH];
  logic [11:0]        word     [NCH];

  wire                aw_take;
  wire                w_take;
  wire                wr_fire;
  wire                ar_take;
  wire                wr_map_ok;
  wire                rd_map_ok;
  wire                wr_ch;
  wire                rd_ch;
  wire  [3:0]         wr_off;
  wire  [3:0]         rd_off;
  wire                wr_lane0;
  wire  [NCH-1:0]     ctrl_wr;
  wire  [NCH-1:0]     low_wr;
  wire  [NCH-1:0]     high_wr;
  wire  [31:0]        rd_mux;

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data may arrive in either order
  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready  = !w_held_reg && !bvalid_reg;
  assign aw_take   = i_awvalid && o_awready;
  assign w_take    = i_wvalid && o_wready;
  assign wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= i_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= i_wdata;
      wstrb_reg  <= i_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= dul_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_map_ok ? dul_pkg::RESP_OKAY : dul_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_reg;
  assign o_bresp  = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode: bit 4 picks the channel, bits 3:0 the register
  assign wr_map_ok = (awaddr_reg[7:5] == dul_pkg::MAP_TOP_BITS) && (awaddr_reg[1:0] == 2'h0);
  assign rd_map_ok = (i_araddr[7:5] == dul_pkg::MAP_TOP_BITS) && (i_araddr[1:0] == 2'h0);
  assign wr_ch     = awaddr_reg[4];
  assign rd_ch     = i_araddr[4];
  assign wr_off    = awaddr_reg[3:0];
  assign rd_off    = i_araddr[3:0];
  // registers are one byte wide, so only lane 0 carries them
  assign wr_lane0  = wr_fire && wr_map_ok && wstrb_reg[0];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign ctrl_wr[g] = wr_lane0 && (wr_ch == 1'(g)) && (wr_off == dul_pkg::OFF_CTRL);
      assign low_wr[g]  = wr_lane0 && (wr_ch == 1'(g)) && (wr_off == dul_pkg::OFF_DATA_LOW);
      assign high_wr[g] = wr_lane0 && (wr_ch == 1'(g)) && (wr_off == dul_pkg::OFF_DATA_HIGH);

      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ctrl_reg[g] <= dul_pkg::CTRL_RESET;
        end else if (ctrl_wr[g]) begin
          ctrl_reg[g] <= wdata_reg[dul_pkg::CTRL_W-1:0];
        end
      end

      // both bytes are only stored here; the channel decides when to copy
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          data_reg[g] <= {dul_pkg::DATA_RESET, dul_pkg::DATA_RESET};
        end else begin
          if (low_wr[g]) begin
            data_reg[g].low <= wdata_reg[7:0];
          end
          if (high_wr[g]) begin
            data_reg[g].high <= wdata_reg[7:0];
          end
        end
      end

      dul_channel u_chan (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_ctrl     (ctrl_reg[g]),
        .i_data     (data_reg[g]),
        .i_high_wr  (high_wr[g]),
        .i_tmr2_ovf (i_tmr2_ovf),
        .i_tmr3_ovf (i_tmr3_ovf),
        .i_tmr4_ovf (i_tmr4_ovf),
        .o_word     (word[g])
      );
    end
  endgenerate

  assign o_first_word  = word[0];
  assign o_second_word = word[1];

  ////////////////////////////////////////////////////////////////////////////////
  // read channel: one read under way at a time
  assign o_arready = !rvalid_reg;
  assign ar_take   = i_arvalid && o_arready;
  assign rd_mux    = !rd_map_ok                        ? 32'h0000_0000 :
                     (rd_off == dul_pkg::OFF_CTRL)      ? {27'h0000000, ctrl_reg[rd_ch]} :
                     (rd_off == dul_pkg::OFF_DATA_LOW)  ? {24'h000000, data_reg[rd_ch].low} :
                     (rd_off == dul_pkg::OFF_DATA_HIGH) ? {24'h000000, data_reg[rd_ch].high} :
                                                          {20'h00000, word[rd_ch]};

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= dul_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_map_ok ? dul_pkg::RESP_OKAY : dul_pkg::RESP_SLVERR;
      rdata_reg  <= rd_mux;
    end else if (i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_reg;
  assign o_rresp  = rresp_reg;
  assign o_rdata  = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_second_high_pulse;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_fire && wr_map_ok && wstrb_reg[0] && awaddr_reg == (dul_pkg::CHAN_STRIDE
      | {4'h0, dul_pkg::OFF_DATA_HIGH})) |=> (data_reg[1].high == $past(wdata_reg[7:0]))
      && $stable(data_reg[0].high);
  endproperty
  a_second_high_pulse: assert property (p_second_high_pulse)
    else $error("second channel high byte write misrouted");

  property p_b_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (o_bvalid && !i_bready) |=> (o_bvalid && $stable(o_bresp));
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");

  property p_unmapped_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (ar_take && !rd_map_ok) |=> (o_rvalid && o_rresp == dul_pkg::RESP_SLVERR && o_rdata == 32'h0);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");

endmodule : dul_dac_latch

//--- dv/tb.sv
// testbench: register bus sequences for the converter update latch block
`timescale 1ns/1ps
module tb;
  localparam int LIMIT = 20000;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  i_awaddr = 8'h00;
  logic        i_awvalid = 1'b0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0]  i_wstrb = 4'h0;
  logic        i_wvalid = 1'b0;
  logic        i_bready = 1'b0;
  logic [7:0]  i_araddr = 8'h00;
  logic        i_arvalid = 1'b0;
  logic        i_rready = 1'b0;
  logic [2:0]  tmr = 3'h0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [11:0] o_first_word, o_second_word;
  logic [11:0] exp_word [2];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  dul_dac_latch u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_awaddr(i_awaddr), .i_awprot(3'h0), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arprot(3'h0), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_tmr2_ovf(tmr[0]), .i_tmr3_ovf(tmr[1]), .i_tmr4_ovf(tmr[2]),
    .o_first_word(o_first_word), .o_second_word(o_second_word)
  );

  always #5 i_sys_clk = ~i_sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // hang guard: a stuck handshake ends the run as a failure
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : chk

  // handshakes decided at the falling edge, taken and released at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic       aw_hs, w_hs, b_hs, b_seen;
    logic [1:0] resp;
    b_hs = 1'b0;
    resp = 2'bxx;
    @(posedge i_sys_clk);
    i_awaddr  <= a;
    i_awvalid <= 1'b1;
    i_wdata   <= {24'h000000, d};
    i_wstrb   <= s;
    i_wvalid  <= 1'b1;
    while (!b_hs) begin
      @(negedge i_sys_clk);
      aw_hs  = i_awvalid && (o_awready === 1'b1);
      w_hs   = i_wvalid && (o_wready === 1'b1);
      b_seen = (o_bvalid === 1'b1);
      b_hs   = i_bready && b_seen;
      resp   = o_bresp;
      @(posedge i_sys_clk);
      if (aw_hs) i_awvalid <= 1'b0;
      if (w_hs) i_wvalid <= 1'b0;
      // late ready: the response has to stand one cycle unanswered
      i_bready <= b_seen && !b_hs;
    end
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [11:0] ed, input logic [1:0] er);
    logic        ar_hs, r_hs;
    logic [31:0] data;
    logic [1:0]  resp;
    r_hs = 1'b0;
    data = 32'hx;
    resp = 2'bxx;
    @(posedge i_sys_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    while (!r_hs) begin
      @(negedge i_sys_clk);
      ar_hs = i_arvalid && (o_arready === 1'b1);
      r_hs  = (o_rvalid === 1'b1);
      data  = o_rdata;
      resp  = o_rresp;
      @(posedge i_sys_clk);
      if (ar_hs) i_arvalid <= 1'b0;
      if (r_hs) i_rready <= 1'b0;
    end
    chk("rresp", {30'h0, er}, {30'h0, resp});
    chk("rdata", {20'h0, ed}, data);
  endtask : rd

  task automatic chk_words();
    @(negedge i_sys_clk);
    chk("first_word", {20'h0, exp_word[0]}, {20'h0, o_first_word});
    chk("second_word", {20'h0, exp_word[1]}, {20'h0, o_second_word});
  endtask : chk_words

  task automatic pulse(input int idx);
    @(posedge i_sys_clk);
    tmr[idx] <= 1'b1;
    @(posedge i_sys_clk);
    tmr <= 3'h0;
  endtask : pulse

  // placement of the 12-bit word in the byte pair, reserved codes as left justified
  function automatic logic [11:0] place(input logic [2:0] f, input logic [7:0] h,
                                        input logic [7:0] l);
    case (f)
      3'h0:    place = {h[3:0], l};
      3'h1:    place = {h[4:0], l[7:1]};
      3'h2:    place = {h[5:0], l[7:2]};
      3'h3:    place = {h[6:0], l[7:3]};
      default: place = {h, l[7:4]};
    endcase
  endfunction : place

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] b;
    logic [7:0] hv, lv;
    int         ch;
    exp_word[0] = 12'h000;
    exp_word[1] = 12'h000;
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (ch = 0; ch < 2; ch++) begin
      b = (ch == 1) ? 8'h10 : 8'h00;
      chk_words();
      rd(b + 8'h00, 12'h000, 2'h0);
      rd(b + 8'h04, 12'h000, 2'h0);
      rd(b + 8'h08, 12'h000, 2'h0);
      // immediate mode: low held, high copies
      wr(b + 8'h04, 8'hCD, 4'hF, 2'h0);
      chk_words();
      wr(b + 8'h08, 8'h0A, 4'hF, 2'h0);
      exp_word[ch] = 12'hACD;
      chk_words();
      // strobe low: bus says okay, nothing stored
      wr(b + 8'h08, 8'h0F, 4'h0, 2'h0);
      rd(b + 8'h08, 12'h00A, 2'h0);
      chk_words();
      // eight-bit use: low once, then high only
      wr(b + 8'h00, 8'h04, 4'hF, 2'h0);
      wr(b + 8'h04, 8'h00, 4'hF, 2'h0);
      foreach (exp_word[i]) begin
        hv = (i == 0) ? 8'h12 : 8'hFF;
        wr(b + 8'h08, hv, 4'hF, 2'h0);
        exp_word[ch] = {hv, 4'h0};
        chk_words();
      end
      for (int f = 0; f < 8; f++) begin
        wr(b + 8'h00, 8'(f), 4'hF, 2'h0);
        rd(b + 8'h00, 12'(f), 2'h0);
        wr(b + 8'h04, 8'h3C, 4'hF, 2'h0);
        wr(b + 8'h08, 8'hA5, 4'hF, 2'h0);
        exp_word[ch] = place(3'(f), 8'hA5, 8'h3C);
        chk_words();
        rd(b + 8'h0C, exp_word[ch], 2'h0);
      end
      // timer modes: held until the selected overflow only
      for (int m = 1; m < 4; m++) begin
        wr(b + 8'h00, 8'(m << 3), 4'hF, 2'h0);
        lv = 8'(8'h10 * m + ch);
        hv = 8'(m);
        wr(b + 8'h04, lv, 4'hF, 2'h0);
        wr(b + 8'h08, hv, 4'hF, 2'h0);
        chk_words();
        pulse((m + 1) % 3);
        pulse((m + 2) % 3);
        chk_words();
        pulse(m % 3);
        exp_word[ch] = {hv[3:0], lv};
        chk_words();
      end
    end
    // unmapped places refuse
    rd(8'h20, 12'h000, 2'h2);
    rd(8'h05, 12'h000, 2'h2);
    wr(8'h21, 8'h55, 4'hF, 2'h2);
    chk_words();
    print_verdict();
  end
endmodule : tb
